// *** rtl/pin_func_block.sv ***
// Purpose: Pin functions for high-speed outputs, error-correct enable,
//          timer 2 capture, port 2 pins 7 and 5, PWM 0 and write strobe
// Assumes: AHB-Lite slave, single word transfers; bus controller on clk_in
// Notes:   All pin outputs are registered or tied off so select changes cannot glitch
`timescale 1ns/10ps

// Functional notes
// R1 - The two high-speed output pins carry only the high-speed output unit's levels.
// R2 - A low error-correct enable activates the engine and the six check bit pins in external cycles.
// R3 - A rising capture edge copies the timer 2 count into the capture register.
// R4 - A rising capture edge also raises the timer 2 capture interrupt.
// R5 - The outside source holds the capture input high for at least two state times.
// R6 - The capture mask bit gates the interrupt but never the capture load.
// R7 - Port 2 pin 7 is quasi-bidirectional and read and written at port 2 offset 10h.
// R8 - Port 2 pin 5 is output only, its level written at port 2 offset 10h.
// R9 - Pin 39 carries PWM 0 when its select bit is one and the pin 5 latch when zero.
// R10 - PWM 0 takes its duty from the duty register and its rate from the frequency select.
// R11 - The write strobe is asserted only in external memory write cycles.
// R12 - Pin 40 carries the single write strobe when the mode bit is one, the low-byte one when zero.
// R13 - The low-byte strobe asserts for low-byte 16-bit writes and every 8-bit bus write.
// R14 - A select bit change reroutes its pin in the following cycle without a glitch.
module pin_func_block
	import pin_func_pkg::*;
(
	// Clock and reset
	input  wire logic                                clk_in,
	input  wire logic                                rstn_in,
	// AHB-Lite slave
	input  wire logic                                hsel_in,
	input  wire logic [31:0]                         haddr_in,
	input  wire logic [1:0]                          htrans_in,
	input  wire logic                                hwrite_in,
	input  wire logic [2:0]                          hsize_in,
	input  wire logic [31:0]                         hwdata_in,
	input  wire logic                                hready_in,
	output logic [31:0]                              hrdata_out,
	output logic                                     hreadyout_out,
	output logic                                     hresp_out,
	// Internal units on this clock
	input  wire logic                                hso_unit_2_in,
	input  wire logic                                hso_unit_3_in,
	input  wire logic [pin_func_pkg::TIMER_WIDTH-1:0] timer2_count_in,
	input  wire logic [pin_func_pkg::CHECK_BITS-1:0]  check_bits_gen_in,
	input  wire logic                                ext_cycle_in,
	input  wire logic                                ext_write_in,
	input  wire logic                                bus16_in,
	input  wire logic                                low_byte_in,
	// Pins
	output logic                                     hs_output_2_out,
	output logic                                     hs_output_3_out,
	input  wire logic                                error_correct_enable_n_in,
	input  wire logic [pin_func_pkg::CHECK_BITS-1:0]  check_bit_pins_in,
	output logic [pin_func_pkg::CHECK_BITS-1:0]       check_bit_pins_out,
	output logic                                     check_bit_pins_oe_out,
	input  wire logic                                port2_pin7_in,
	output logic                                     port2_pin7_out,
	output logic                                     port2_pin7_oe_out,
	output logic                                     pin39_out,
	output logic                                     pin40_n_out,
	// To the error-correct engine and interrupt controller
	output logic                                     ecc_active_out,
	output logic [pin_func_pkg::CHECK_BITS-1:0]       check_bits_read_out,
	output logic                                     capture_interrupt_line_out
);

	typedef struct packed {
		// Bus
		logic                   wr_pend;
		logic [7:0]             wr_addr;
		logic [31:0]            rdata;
		// Registers
		logic                   pin39_func_sel;
		logic                   pwm_freq_sel;
		logic                   write_mode_sel;
		logic [PWM_WIDTH-1:0]   pwm_zero_duty_reg;
		logic [TIMER_WIDTH-1:0] capture;
		logic                   cap_status;
		logic                   capture_irq_mask_bit;
		logic                   latch7;
		logic                   latch5;
		// Synchronisers
		logic [1:0]             cap_sync;
		logic                   cap_prev;
		logic [1:0]             ecc_sync;
		logic [CHECK_BITS-1:0]  cb_sync1;
		logic [CHECK_BITS-1:0]  cb_sync2;
		// Registered pins
		logic                   hs2;
		logic                   hs3;
		logic                   pin39;
		logic                   pin40_n;
		logic [CHECK_BITS-1:0]  cb_out;
		logic                   cb_oe;
		logic [CHECK_BITS-1:0]  cb_read;
		logic                   irq;
	} blk_state_t;

	blk_state_t state;
	blk_state_t next_state;
	logic       pwm_wave;
	logic       cap_rise;
	logic       addr_take;
	logic [7:0] rd_off;
	logic [31:0] rd_word;

	// ----------------------------------------------------------------
	// PWM 0 generator
	// ----------------------------------------------------------------
	pwm_zero_gen #(
		.WIDTH      (PWM_WIDTH)
	) u_pwm (
		.clk_in      (clk_in),
		.rstn_in     (rstn_in),
		.duty_in     (state.pwm_zero_duty_reg), // R10
		.freq_sel_in (state.pwm_freq_sel),      // R10
		.pwm_out     (pwm_wave)
	);

	// ----------------------------------------------------------------
	// Read mux for the address phase
	// ----------------------------------------------------------------
	always_comb begin
		rd_off  = haddr_in[7:0];
		rd_word = '0;
		unique case (rd_off)
			OFF_PIN_CTRL: begin
				rd_word[BIT_PIN39_SEL] = state.pin39_func_sel;
				rd_word[BIT_FREQ_SEL]  = state.pwm_freq_sel;
				rd_word[BIT_WMODE_SEL] = state.write_mode_sel;
			end
			OFF_PWM_DUTY:   rd_word[PWM_WIDTH-1:0] = state.pwm_zero_duty_reg;
			OFF_CAPTURE:    rd_word[TIMER_WIDTH-1:0] = state.capture;
			OFF_IRQ_STATUS: rd_word[BIT_CAPTURE] = state.cap_status;
			OFF_PORT2: begin
				rd_word[BIT_PORT2_PIN7] = state.cap_sync[1]; // R7
				rd_word[BIT_PORT2_PIN5] = state.latch5;
			end
			OFF_IRQ_MASK:   rd_word[BIT_CAPTURE] = state.capture_irq_mask_bit;
			default:        rd_word = '0; // Unmapped reads as zero
		endcase
	end

	// Valid address phase on a selected, ready bus
	assign addr_take = hsel_in && hready_in && htrans_in[1];
	// Rising edge only from the second and third stages
	assign cap_rise  = state.cap_sync[1] && !state.cap_prev;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_state = state;

		// Bus: writes land in the data phase, reads are loaded early
		next_state.wr_pend = addr_take && hwrite_in;
		next_state.wr_addr = haddr_in[7:0];
		if (addr_take && !hwrite_in) begin
			next_state.rdata = rd_word;
		end
		if (state.wr_pend) begin
			unique case (state.wr_addr)
				OFF_PIN_CTRL: begin
					next_state.pin39_func_sel = hwdata_in[BIT_PIN39_SEL]; // R14
					next_state.pwm_freq_sel   = hwdata_in[BIT_FREQ_SEL];
					next_state.write_mode_sel = hwdata_in[BIT_WMODE_SEL];
				end
				OFF_PWM_DUTY: next_state.pwm_zero_duty_reg = hwdata_in[PWM_WIDTH-1:0];
				OFF_PORT2: begin
					next_state.latch7 = hwdata_in[BIT_PORT2_PIN7]; // R7
					next_state.latch5 = hwdata_in[BIT_PORT2_PIN5]; // R8
				end
				OFF_IRQ_MASK: next_state.capture_irq_mask_bit = hwdata_in[BIT_CAPTURE];
				OFF_IRQ_STATUS: begin
					if (hwdata_in[BIT_CAPTURE]) begin
						next_state.cap_status = 1'b0;
					end
				end
				default: ;
			endcase
		end

		// Capture pin shares pin 7; sync before any use
		next_state.cap_sync = {state.cap_sync[0], port2_pin7_in};
		next_state.cap_prev = state.cap_sync[1];
		if (cap_rise) begin
			next_state.capture    = timer2_count_in; // R3 R6
			next_state.cap_status = 1'b1;            // R4
		end
		// Mask gates the line only; set already wins over a clear above
		next_state.irq = next_state.cap_status && next_state.capture_irq_mask_bit; // R6

		// Dedicated outputs pass straight from the output unit
		next_state.hs2 = hso_unit_2_in; // R1
		next_state.hs3 = hso_unit_3_in; // R1

		// Error-correct enable and check bits
		next_state.ecc_sync = {state.ecc_sync[0], error_correct_enable_n_in};
		next_state.cb_out   = check_bits_gen_in;
		next_state.cb_oe    = !state.ecc_sync[1] && ext_cycle_in && ext_write_in; // R2
		next_state.cb_sync1 = check_bit_pins_in;
		next_state.cb_sync2 = state.cb_sync1;
		if (!state.ecc_sync[1] && ext_cycle_in && !ext_write_in) begin
			next_state.cb_read = state.cb_sync2; // R2
		end

		// Pin 39 routing, registered so the swap is clean
		next_state.pin39 = state.pin39_func_sel ? pwm_wave : state.latch5; // R9 R14

		// Pin 40 strobe, only for external writes
		if (state.write_mode_sel) begin
			next_state.pin40_n = !(ext_cycle_in && ext_write_in); // R11 R12
		end else begin
			next_state.pin40_n = !(ext_cycle_in && ext_write_in
				&& (!bus16_in || low_byte_in)); // R12 R13
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state                      <= '0;
			state.pin39_func_sel       <= RST_PIN_CTRL[BIT_PIN39_SEL];
			state.pwm_freq_sel         <= RST_PIN_CTRL[BIT_FREQ_SEL];
			state.write_mode_sel       <= RST_PIN_CTRL[BIT_WMODE_SEL];
			state.pwm_zero_duty_reg    <= RST_PWM_DUTY;
			state.capture_irq_mask_bit <= RST_IRQ_MASK[BIT_CAPTURE];
			state.latch7               <= RST_PORT2[BIT_PORT2_PIN7];
			state.latch5               <= RST_PORT2[BIT_PORT2_PIN5];
			state.ecc_sync             <= 2'h3;
			// Pin 7 idles high on its pull-up; start there so release is no false edge
			state.cap_sync             <= 2'h3;
			state.cap_prev             <= 1'b1;
			state.pin39                <= RST_PORT2[BIT_PORT2_PIN5];
			state.pin40_n              <= 1'b1;
		end else begin
			state <= next_state;
		end
	end

	// ----------------------------------------------------------------
	// Outputs, from flip-flops except the tied-off constants
	// ----------------------------------------------------------------
	assign hrdata_out                 = state.rdata;
	assign hreadyout_out              = 1'b1; // Zero wait states
	assign hresp_out                  = 1'b0; // Always OKAY
	assign hs_output_2_out            = state.hs2;
	assign hs_output_3_out            = state.hs3;
	assign check_bit_pins_out         = state.cb_out;
	assign check_bit_pins_oe_out      = state.cb_oe;
	// Quasi pin: strong low only, weak pull-up outside does the high
	assign port2_pin7_out             = 1'b0;
	assign port2_pin7_oe_out          = !state.latch7; // R7
	assign pin39_out                  = state.pin39;
	assign pin40_n_out                = state.pin40_n;
	assign ecc_active_out             = !state.ecc_sync[1]; // R2
	assign check_bits_read_out        = state.cb_read;
	assign capture_interrupt_line_out = state.irq;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_hso_passthru: assert property (@(posedge clk_in) disable iff (!rstn_in) // R1
		##1 (hs_output_2_out == $past(hso_unit_2_in)) && (hs_output_3_out == $past(hso_unit_3_in)))
		else $error("high-speed output not copied from unit");

	chk_ecc_enable: assert property (@(posedge clk_in) disable iff (!rstn_in) // R2
		(!error_correct_enable_n_in) [*3] |-> ecc_active_out)
		else $error("error-correct engine not active after enable held low");

	chk_check_oe: assert property (@(posedge clk_in) disable iff (!rstn_in) // R2
		check_bit_pins_oe_out |-> $past(ext_cycle_in && ext_write_in && ecc_active_out))
		else $error("check bits driven outside an enabled external write");

	chk_capture_load: assert property (@(posedge clk_in) disable iff (!rstn_in) // R3 R6
		cap_rise |=> (state.capture == $past(timer2_count_in)))
		else $error("capture register did not load timer 2 count");

	chk_capture_irq: assert property (@(posedge clk_in) disable iff (!rstn_in) // R4
		(cap_rise && state.capture_irq_mask_bit && !(state.wr_pend
			&& state.wr_addr == OFF_IRQ_MASK)) |=> capture_interrupt_line_out)
		else $error("unmasked capture edge raised no interrupt");

	chk_irq_masked: assert property (@(posedge clk_in) disable iff (!rstn_in) // R6
		(!state.capture_irq_mask_bit && $stable(state.capture_irq_mask_bit))
			|-> !capture_interrupt_line_out)
		else $error("masked capture raised the interrupt line");

	chk_pin7_quasi: assert property (@(posedge clk_in) disable iff (!rstn_in) // R7
		(state.wr_pend && state.wr_addr == OFF_PORT2)
			|=> (port2_pin7_oe_out == !$past(hwdata_in[BIT_PORT2_PIN7])))
		else $error("pin 7 drive does not follow its latch");

	chk_pin39_pwm: assert property (@(posedge clk_in) disable iff (!rstn_in) // R9 R14
		state.pin39_func_sel |=> (pin39_out == $past(pwm_wave)))
		else $error("pin 39 not carrying PWM 0");

	chk_pin39_port: assert property (@(posedge clk_in) disable iff (!rstn_in) // R8 R9
		!state.pin39_func_sel |=> (pin39_out == $past(state.latch5)))
		else $error("pin 39 not carrying port 2 pin 5");

	chk_strobe_ext_only: assert property (@(posedge clk_in) disable iff (!rstn_in) // R11
		!(ext_cycle_in && ext_write_in) |=> pin40_n_out)
		else $error("write strobe outside an external write");

	chk_single_strobe: assert property (@(posedge clk_in) disable iff (!rstn_in) // R12
		(state.write_mode_sel && ext_cycle_in && ext_write_in) |=> !pin40_n_out)
		else $error("single strobe missing on external write");

	chk_low_strobe: assert property (@(posedge clk_in) disable iff (!rstn_in) // R13
		(!state.write_mode_sel && ext_cycle_in && ext_write_in)
			|=> (pin40_n_out == $past(bus16_in && !low_byte_in)))
		else $error("low-byte strobe wrong for bus width or byte");

endmodule : pin_func_block

// *** rtl/pin_func_pkg.sv ***
// Purpose: Shared constants for the port 2 / write strobe pin function block
// Assumes: 32-bit AHB-Lite register bus, one word per register
// Notes:   Offsets are byte addresses
package pin_func_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_PIN_CTRL   = 8'h00; // Function select bits
	localparam logic [7:0] OFF_PWM_DUTY   = 8'h04; // PWM 0 duty
	localparam logic [7:0] OFF_CAPTURE    = 8'h08; // Timer 2 capture value
	localparam logic [7:0] OFF_IRQ_STATUS = 8'h0c; // Sticky events, write one to clear
	localparam logic [7:0] OFF_PORT2      = 8'h10; // Port 2 in register window zero
	localparam logic [7:0] OFF_IRQ_MASK   = 8'h14; // Same layout as status

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int BIT_PIN39_SEL  = 0; // 1: PWM 0 on pin 39, 0: port 2 pin 5
	localparam int BIT_FREQ_SEL   = 1; // PWM frequency select
	localparam int BIT_WMODE_SEL  = 2; // 1: single strobe, 0: low-byte strobe
	localparam int BIT_CAPTURE    = 3; // Capture event in status and mask
	localparam int BIT_PORT2_PIN5 = 5;
	localparam int BIT_PORT2_PIN7 = 7;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [2:0] RST_PIN_CTRL = 3'h0;
	localparam logic [7:0] RST_PORT2    = 8'hff; // Quasi pins idle high
	localparam logic [7:0] RST_PWM_DUTY = 8'h00;
	localparam logic [3:0] RST_IRQ_MASK = 4'h0;

	// ----------------------------------------------------------------
	// Bus encodings and counts
	// ----------------------------------------------------------------
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ    = 2'h3;
	localparam int         PWM_WIDTH     = 8;
	localparam int         TIMER_WIDTH   = 16;
	localparam int         CHECK_BITS    = 6;

endpackage : pin_func_pkg

// *** rtl/pwm_zero_gen.sv ***
// Purpose: PWM output 0 waveform generator
// Assumes: Duty and frequency select come from registers on the same clock
// Notes:   Output is high while the period counter is below the duty value
`timescale 1ns/10ps
module pwm_zero_gen #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic             clk_in,
	input  wire logic             rstn_in,
	// Settings
	input  wire logic [WIDTH-1:0] duty_in,
	input  wire logic             freq_sel_in,
	// Waveform
	output logic                  pwm_out
);

	typedef struct packed {
		logic [WIDTH-1:0] count;
		logic             half;
		logic             wave;
	} pwm_state_t;

	pwm_state_t state;
	pwm_state_t next_state;

	// ----------------------------------------------------------------
	// Period counter, halved rate when frequency select is set
	// ----------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_state.half = ~state.half;
		if (!freq_sel_in || state.half) begin
			next_state.count = state.count + 1'b1;
		end
		// Compare on the next count so the wave tracks it with no lag
		next_state.wave = (next_state.count < duty_in);
	end

	// State register
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign pwm_out = state.wave;

endmodule : pwm_zero_gen

// *** testbench/pin_board.sv ***
// Purpose: Board model for the pin group: pull-up, capture source, memory
// Assumes: Memory answers check bits on external reads while the device is not driving them
// Notes:   Released check pins show the inverse of their last level
`timescale 1ns/10ps
module pin_board #(
	parameter logic [5:0] MEM_BITS = 6'h2d
) (
	// Clock
	input  wire logic       clk_in,
	// From the device
	input  wire logic       pin7_oe_in,
	input  wire logic       check_oe_in,
	input  wire logic [5:0] check_drv_in,
	input  wire logic       ext_read_in,
	// From the bench
	input  wire logic       pull_low_in,
	input  wire logic       ecc_on_in,
	// To the device
	output logic            pin7_out,
	output logic            ecc_n_out,
	output logic [5:0]      check_pins_out
);
	// --------------------------------------------------------------
	// Pin levels
	// --------------------------------------------------------------
	logic [5:0] last = 6'h00;

	// Pull-up wins unless the device or the capture source pulls low
	assign pin7_out = !(pin7_oe_in | pull_low_in);
	assign ecc_n_out = !ecc_on_in;
	// Device, memory, or a float that never repeats the last value
	assign check_pins_out = check_oe_in ? check_drv_in : ext_read_in ? MEM_BITS : ~last;

	// Remember the wire so a float can invert it
	always @(posedge clk_in) begin
		last <= check_pins_out;
	end
endmodule : pin_board

// *** testbench/tb.sv ***
// Purpose: Self-checking bench for the pin function block
// Assumes: Bus slave has no wait states; board model sits on the pins
// Notes:   Run ends in end_sim from the main sequence or the watchdog
`timescale 1ns/10ps
module tb;
	import pin_func_pkg::*;

	// --------------------------------------------------------------
	// Signals
	// --------------------------------------------------------------
	logic        clk_in = 1'b0, rstn_in, hsel_in, hwrite_in, hso_unit_2_in, hso_unit_3_in;
	logic        ext_cycle_in, ext_write_in, bus16_in, low_byte_in, hreadyout_out, hresp_out;
	logic        hs_output_2_out, hs_output_3_out, error_correct_enable_n_in, port2_pin7_in;
	logic        port2_pin7_out, port2_pin7_oe_out, pin39_out, pin40_n_out, ecc_active_out;
	logic        check_bit_pins_oe_out, capture_interrupt_line_out, pull_low, ecc_on;
	logic [1:0]  htrans_in;
	logic [2:0]  hsize_in;
	logic [5:0]  check_bits_gen_in, check_bit_pins_in, check_bit_pins_out, check_bits_read_out;
	logic [15:0] timer2_count_in;
	logic [31:0] haddr_in, hwdata_in, hrdata_out;
	int          err_count = 0, compares = 0;

	// 100 MHz clock
	always #5 clk_in = ~clk_in;

	pin_func_block dut (
		.clk_in, .rstn_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hsize_in, .hwdata_in,
		.hready_in(hreadyout_out), .hrdata_out, .hreadyout_out, .hresp_out, .hso_unit_2_in,
		.hso_unit_3_in, .timer2_count_in, .check_bits_gen_in, .ext_cycle_in, .ext_write_in,
		.bus16_in, .low_byte_in, .hs_output_2_out, .hs_output_3_out, .error_correct_enable_n_in,
		.check_bit_pins_in, .check_bit_pins_out, .check_bit_pins_oe_out, .port2_pin7_in,
		.port2_pin7_out, .port2_pin7_oe_out, .pin39_out, .pin40_n_out, .ecc_active_out,
		.check_bits_read_out, .capture_interrupt_line_out
	);

	pin_board board (
		.clk_in, .pin7_oe_in(port2_pin7_oe_out), .check_oe_in(check_bit_pins_oe_out),
		.check_drv_in(check_bit_pins_out), .ext_read_in(ext_cycle_in & ~ext_write_in),
		.pull_low_in(pull_low), .ecc_on_in(ecc_on), .pin7_out(port2_pin7_in),
		.ecc_n_out(error_correct_enable_n_in), .check_pins_out(check_bit_pins_in)
	);

	// --------------------------------------------------------------
	// Checks and bus access
	// --------------------------------------------------------------
	task automatic chk_bit(input logic got, input logic exp, input string what);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("FAIL %0t %s got %b exp %b", $time, what, got, exp);
		end
	endtask : chk_bit

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk_word

	// One single word transfer; the wait ends only by hready or the watchdog
	task automatic bus_xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
			output logic [31:0] rd);
		@(posedge clk_in);
		hsel_in   <= 1'b1;
		htrans_in <= HTRANS_NONSEQ;
		haddr_in  <= {24'h0, a};
		hwrite_in <= wr;
		hsize_in  <= 3'h2;
		@(posedge clk_in);
		while (hreadyout_out !== 1'b1) @(posedge clk_in);
		htrans_in <= 2'h0;
		hwdata_in <= wd;
		@(posedge clk_in);
		while (hreadyout_out !== 1'b1) @(posedge clk_in);
		rd = hrdata_out;
	endtask : bus_xfer

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] unused;
		bus_xfer(1'b1, a, d, unused);
	endtask : wr_reg

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] got;
		bus_xfer(1'b0, a, 32'h0, got);
		chk_word(got, exp, "register read");
	endtask : rd_chk

	// Source pulls the capture pin low, then holds it high long enough
	task automatic capture_pulse;
		@(posedge clk_in) pull_low <= 1'b1;
		repeat (3) @(posedge clk_in);
		pull_low <= 1'b0;
		repeat (8) @(posedge clk_in);
	endtask : capture_pulse

	// Duty 0x40 gives a quarter high; rises count the period
	task automatic pwm_measure(input logic fsel, input int exp_rise);
		int   hi;
		int   rise;
		logic prev;
		wr_reg(OFF_PIN_CTRL, {30'h0, fsel, 1'b1});
		repeat (600) @(posedge clk_in);
		hi = 0;
		rise = 0;
		@(negedge clk_in);
		prev = pin39_out;
		repeat (1024) begin
			@(negedge clk_in);
			hi += int'(pin39_out === 1'b1);
			rise += int'(pin39_out === 1'b1 && prev === 1'b0);
			prev = pin39_out;
		end
		chk_word(32'(hi), 32'd256, "pwm high time");
		chk_word(32'(rise), 32'(exp_rise), "pwm periods");
	endtask : pwm_measure

	task automatic end_sim;
		$display("Compares %0d, errors %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : end_sim

	// Watchdog, well beyond the few thousand cycles the tests need
	initial begin
		repeat (20000) @(posedge clk_in);
		err_count++;
		end_sim;
	end

	// --------------------------------------------------------------
	// Tests
	// --------------------------------------------------------------
	initial begin
		{rstn_in, hsel_in, hwrite_in, hso_unit_2_in, hso_unit_3_in, pull_low, ecc_on} = 7'h0;
		{ext_cycle_in, ext_write_in, bus16_in, low_byte_in} = 4'h0;
		{htrans_in, hsize_in, haddr_in, hwdata_in} = '0;
		check_bits_gen_in = 6'h15;
		timer2_count_in = 16'h5a3c;
		repeat (8) @(posedge clk_in);
		chk_word({26'h0, hreadyout_out, hresp_out, pin40_n_out, pin39_out,
			capture_interrupt_line_out, port2_pin7_oe_out}, 32'h2c, "reset pins");
		rstn_in <= 1'b1;
		rd_chk(OFF_PIN_CTRL, 32'h0);
		rd_chk(OFF_PWM_DUTY, 32'h0);
		rd_chk(OFF_IRQ_MASK, 32'h0);
		rd_chk(8'h20, 32'h0);
		rd_chk(OFF_PORT2, 32'ha0);
		// High-speed outputs follow their unit only
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_in) {hso_unit_2_in, hso_unit_3_in} <= 2'(i);
			@(negedge clk_in);
			@(negedge clk_in);
			chk_word({30'h0, hs_output_2_out, hs_output_3_out}, 32'(i), "hs outputs");
		end
		// Every bus controller state in both write modes
		for (int m = 0; m < 2; m++) begin
			wr_reg(OFF_PIN_CTRL, 32'(m) << BIT_WMODE_SEL);
			for (int c = 0; c < 16; c++) begin
				@(posedge clk_in) {ext_cycle_in, ext_write_in, bus16_in, low_byte_in} <= 4'(c);
				@(negedge clk_in);
				@(negedge clk_in);
				chk_bit(pin40_n_out, !(c[3] && c[2] && (m == 1 || !c[1] || c[0])), "strobe");
				chk_bit(check_bit_pins_oe_out, 1'b0, "check oe off");
			end
		end
		// Error-correct engine: drive on writes, sample on reads
		@(posedge clk_in) ecc_on <= 1'b1;
		{ext_cycle_in, ext_write_in} <= 2'h3;
		repeat (5) @(negedge clk_in);
		chk_bit(ecc_active_out, 1'b1, "ecc active");
		chk_bit(check_bit_pins_oe_out, 1'b1, "check oe on");
		chk_word({26'h0, check_bit_pins_out}, 32'h15, "check bits out");
		@(posedge clk_in) ext_write_in <= 1'b0;
		repeat (5) @(negedge clk_in);
		chk_word({26'h0, check_bits_read_out}, 32'h2d, "check bits in");
		@(posedge clk_in) ext_cycle_in <= 1'b0;
		// Port 2: quasi pin 7 and output pin 5
		wr_reg(OFF_PORT2, 32'h0);
		repeat (2) @(negedge clk_in);
		chk_bit(port2_pin7_oe_out, 1'b1, "pin7 pulls low");
		chk_bit(port2_pin7_out, 1'b0, "pin7 drives low only");
		chk_bit(pin39_out, 1'b0, "pin5 on pin39");
		rd_chk(OFF_PORT2, 32'h0);
		wr_reg(OFF_PORT2, 32'ha0);
		@(posedge clk_in) pull_low <= 1'b1;
		repeat (3) @(posedge clk_in);
		rd_chk(OFF_PORT2, 32'h20);
		pull_low <= 1'b0;
		repeat (8) @(posedge clk_in);
		// Capture loads regardless of mask; mask gates the interrupt
		wr_reg(OFF_IRQ_STATUS, 32'h8);
		timer2_count_in <= 16'h1234;
		rd_chk(OFF_IRQ_STATUS, 32'h0);
		capture_pulse;
		chk_bit(capture_interrupt_line_out, 1'b0, "masked irq");
		rd_chk(OFF_CAPTURE, 32'h1234);
		rd_chk(OFF_IRQ_STATUS, 32'h8);
		wr_reg(OFF_IRQ_MASK, 32'h8);
		repeat (2) @(negedge clk_in);
		chk_bit(capture_interrupt_line_out, 1'b1, "unmasked irq");
		wr_reg(OFF_IRQ_STATUS, 32'h8);
		repeat (2) @(negedge clk_in);
		chk_bit(capture_interrupt_line_out, 1'b0, "cleared irq");
		@(posedge clk_in) timer2_count_in <= 16'hbeef;
		capture_pulse;
		chk_bit(capture_interrupt_line_out, 1'b1, "second irq");
		rd_chk(OFF_CAPTURE, 32'hbeef);
		// Select change with duty 0: pin39 leaves latch 1 one cycle later
		wr_reg(OFF_PWM_DUTY, 32'h0);
		wr_reg(OFF_PIN_CTRL, 32'h1);
		@(negedge clk_in);
		chk_bit(pin39_out, 1'b1, "old route");
		@(negedge clk_in);
		chk_bit(pin39_out, 1'b0, "pwm route");
		wr_reg(OFF_PWM_DUTY, 32'h40);
		pwm_measure(1'b0, 4);
		pwm_measure(1'b1, 2);
		end_sim;
	end
endmodule : tb
